// [logic/eagc_pkg.sv]
// Purpose: constants, register map and carrier types for the energy accumulation / gain configuration block
// Assumes: 8-bit register port, one 25 MHz clock
// Notes:   offsets are byte addresses on the plain register port
package eagc_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] ADDR_ACC_MODE  = 8'h0f;
  localparam logic [7:0] ADDR_GAIN      = 8'h1b;
  localparam logic [7:0] ADDR_ZX_CTRL   = 8'h2b;
  localparam logic [7:0] ADDR_CAL_CTRL  = 8'h3d;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'hd9;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'hdc;

  localparam logic [7:0] RST_ACC_MODE   = 8'h00;
  localparam logic [7:0] RST_GAIN       = 8'h00;
  localparam logic [7:0] RST_ZX_CTRL    = 8'h00;
  localparam logic [7:0] RST_CAL_CTRL   = 8'h00;
  localparam logic [2:0] RST_IRQ        = 3'h0;

  // ****************************************************************
  // field positions
  // ****************************************************************
  // accumulation mode
  localparam int TAMPER_CURRENT_INPUT_IND   = 7;
  localparam int FAULT_EVENT_SELECT         = 6;
  localparam int REACTIVE_SIGN_EVENT_SELECT = 5;
  localparam int ACTIVE_SIGN_EVENT_SELECT   = 4;
  localparam int REACTIVE_ABSOLUTE_MODE     = 3;
  localparam int REACTIVE_SIGNED_BY_ACTIVE  = 2;
  localparam int ACTIVE_POSITIVE_ONLY       = 1;
  localparam int ACTIVE_ABSOLUTE_MODE       = 0;
  // channel gain
  localparam int VOLTAGE_GAIN_HI            = 7;
  localparam int VOLTAGE_GAIN_LO            = 5;
  localparam int SIGN_DETECTION_SOURCE      = 3;
  localparam int CURRENT_GAIN_HI            = 2;
  localparam int CURRENT_GAIN_LO            = 0;
  localparam logic [7:0] GAIN_WR_MASK       = 8'hef;
  // zero-cross output control
  localparam int ZERO_CROSS_OUT_ENABLE_A    = 1;
  localparam int ZERO_CROSS_OUT_ENABLE_B    = 0;
  localparam logic [7:0] ZX_WR_MASK         = 8'h03;
  // calibration channel control
  localparam int CURRENT_INPUT_SELECT_HI    = 5;
  localparam int CURRENT_INPUT_SELECT_LO    = 4;
  localparam int VOLTAGE_INPUT_SHORT        = 3;
  localparam int CURRENT_INPUT_SHORT        = 2;
  // interrupt status / mask
  localparam int IRQ_SUMMARY                = 7;
  localparam int IRQ_FAULT                  = 5;
  localparam int IRQ_REACTIVE_SIGN          = 4;
  localparam int IRQ_ACTIVE_SIGN            = 3;
  localparam int IRQ_LO                     = 3;

  // current input select codes
  localparam logic [1:0] SEL_FORCE_A        = 2'h1;
  localparam logic [1:0] SEL_FORCE_B        = 2'h2;
  // largest gain code (x16)
  localparam logic [2:0] GAIN_CODE_MAX      = 3'h4;

  localparam int PWR_W = 24;

  // ****************************************************************
  // carrier types
  // ****************************************************************
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } eagc_bus_req_t;

  typedef struct packed {
    logic                    vld;
    logic signed [PWR_W-1:0] act;
    logic signed [PWR_W-1:0] rea;
  } eagc_power_t;

endpackage : eagc_pkg

// [logic/eagc_core.sv]
// Purpose: accumulation mode, gain, zero-cross output and channel control registers of a meter front end
// Assumes: power samples, pulse strobes, fault and tamper levels come from logic on clk_sys
// Notes:   configuration written by software, except the interrupt mask, is applied at the next measurement update
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
module eagc_core
  import eagc_pkg::*;
(
  input  wire logic                       clk_sys,
  input  wire logic                       rst_n,
  input  wire eagc_pkg::eagc_bus_req_t    bus_req,
  output logic [7:0]                      bus_rdata,
  input  wire logic                       meas_update,
  input  wire eagc_pkg::eagc_power_t      power_in,
  input  wire logic                       act_pulse,
  input  wire logic                       rea_pulse,
  input  wire logic                       fault_mode,
  input  wire logic                       tamper_use_b,
  input  wire logic                       zero_cross,
  output eagc_pkg::eagc_power_t           accum_out,
  output logic [2:0]                      voltage_gain_shift,
  output logic [2:0]                      current_gain_shift,
  output logic                            current_input_b_sel,
  output logic                            voltage_input_short,
  output logic                            current_input_short,
  output logic                            zx_line_a_out,
  output logic                            zx_line_a_oe,
  output logic                            zx_line_b_out,
  output logic                            zx_line_b_oe,
  output logic                            irq
);

  import eagc_pkg::*;

  // ****************************************************************
  // functions
  // ****************************************************************
  // magnitude; most negative value wraps, one lsb in 2^23 is harmless here
  function automatic logic signed [PWR_W-1:0] mag(input logic signed [PWR_W-1:0] v);
    mag = v[PWR_W-1] ? -v : v;
  endfunction : mag

  // gain code to shift; reserved codes clamp to the largest gain
  function automatic logic [2:0] gain_shift(input logic [2:0] code);
    gain_shift = (code > GAIN_CODE_MAX) ? GAIN_CODE_MAX : code;
  endfunction : gain_shift

  // ****************************************************************
  // software copies and applied copies
  // ****************************************************************
  logic [7:0]              acc_mode_ff;
  logic [7:0]              gain_ff;
  logic [7:0]              zx_ctrl_ff;
  logic [7:0]              cal_ctrl_ff;
  logic [7:0]              acc_mode_act_ff;
  logic [7:0]              gain_act_ff;
  logic [7:0]              zx_ctrl_act_ff;
  logic [7:0]              cal_ctrl_act_ff;
  logic [2:0]              irq_stat_ff;
  logic [2:0]              irq_mask_ff;
  logic [2:0]              nxt_irq_stat;
  logic [7:0]              rdata_ff;
  logic                    chan_b_ff;
  logic                    act_neg_ff;
  logic                    rea_neg_ff;
  logic                    act_seen_ff;
  logic                    rea_seen_ff;
  logic                    fault_ff;
  logic                    act_src_vld;
  logic                    rea_src_vld;
  logic                    act_now_neg;
  logic                    rea_now_neg;
  logic                    act_evt;
  logic                    rea_evt;
  logic                    fault_evt;
  logic signed [PWR_W-1:0] nxt_act;
  logic signed [PWR_W-1:0] nxt_rea;
  eagc_power_t             accum_ff;

  wire wr_acc  = bus_req.wr && (bus_req.addr == ADDR_ACC_MODE);
  wire wr_gain = bus_req.wr && (bus_req.addr == ADDR_GAIN);
  wire wr_zx   = bus_req.wr && (bus_req.addr == ADDR_ZX_CTRL);
  wire wr_cal  = bus_req.wr && (bus_req.addr == ADDR_CAL_CTRL);
  wire wr_mask = bus_req.wr && (bus_req.addr == ADDR_IRQ_MASK);
  wire wr_stat = bus_req.wr && (bus_req.addr == ADDR_IRQ_STAT);

  // ****************************************************************
  // register writes
  // ****************************************************************
  // bit 7 of accumulation mode is status, so it is never stored
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      acc_mode_ff <= RST_ACC_MODE;
      gain_ff     <= RST_GAIN;
      zx_ctrl_ff  <= RST_ZX_CTRL;
      cal_ctrl_ff <= RST_CAL_CTRL;
      irq_mask_ff <= RST_IRQ;
    end else begin
      if (wr_acc)
        acc_mode_ff <= {1'b0, bus_req.wdata[6:0]};
      if (wr_gain)
        gain_ff <= bus_req.wdata & GAIN_WR_MASK;
      if (wr_zx)
        zx_ctrl_ff <= bus_req.wdata & ZX_WR_MASK;
      // stored as written; nonzero reserved bits are the writer's fault
      if (wr_cal)
        cal_ctrl_ff <= bus_req.wdata;
      if (wr_mask)
        irq_mask_ff <= bus_req.wdata[IRQ_FAULT:IRQ_LO];
    end
  end

  // applied copies change only on a measurement update, never mid-sample
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      acc_mode_act_ff <= RST_ACC_MODE;
      gain_act_ff     <= RST_GAIN;
      zx_ctrl_act_ff  <= RST_ZX_CTRL;
      cal_ctrl_act_ff <= RST_CAL_CTRL;
    end else if (meas_update) begin
      acc_mode_act_ff <= acc_mode_ff;
      gain_act_ff     <= gain_ff;
      zx_ctrl_act_ff  <= zx_ctrl_ff;
      cal_ctrl_act_ff <= cal_ctrl_ff;
    end
  end

  // ****************************************************************
  // channel selection and gain
  // ****************************************************************
  wire [1:0] sel_code = cal_ctrl_act_ff[CURRENT_INPUT_SELECT_HI:CURRENT_INPUT_SELECT_LO];

  // forced codes override tamper; 00 and 11 follow the tamper decision
  always_ff @(posedge clk_sys) begin
    if (!rst_n)
      chan_b_ff <= 1'b0;
    else if (sel_code == SEL_FORCE_A)
      chan_b_ff <= 1'b0;
    else if (sel_code == SEL_FORCE_B)
      chan_b_ff <= 1'b1;
    else
      chan_b_ff <= tamper_use_b;
  end

  assign current_input_b_sel = chan_b_ff;
  assign voltage_input_short = cal_ctrl_act_ff[VOLTAGE_INPUT_SHORT];
  assign current_input_short = cal_ctrl_act_ff[CURRENT_INPUT_SHORT];
  assign voltage_gain_shift  = gain_shift(gain_act_ff[VOLTAGE_GAIN_HI:VOLTAGE_GAIN_LO]);
  assign current_gain_shift  = gain_shift(gain_act_ff[CURRENT_GAIN_HI:CURRENT_GAIN_LO]);

  // ****************************************************************
  // zero-cross port lines
  // ****************************************************************
  assign zx_line_a_out = zero_cross;
  assign zx_line_a_oe  = zx_ctrl_act_ff[ZERO_CROSS_OUT_ENABLE_A];
  assign zx_line_b_out = zero_cross;
  assign zx_line_b_oe  = zx_ctrl_act_ff[ZERO_CROSS_OUT_ENABLE_B];

  // ****************************************************************
  // accumulation modes
  // ****************************************************************
  // absolute wins over positive-only and signed-by-active when both are set
  always_comb begin
    nxt_act = power_in.act;
    if (acc_mode_act_ff[ACTIVE_ABSOLUTE_MODE])
      nxt_act = mag(power_in.act);
    else if (acc_mode_act_ff[ACTIVE_POSITIVE_ONLY] && power_in.act[PWR_W-1])
      nxt_act = '0;
    nxt_rea = power_in.rea;
    if (acc_mode_act_ff[REACTIVE_ABSOLUTE_MODE])
      nxt_rea = mag(power_in.rea);
    else if (acc_mode_act_ff[REACTIVE_SIGNED_BY_ACTIVE] && power_in.act[PWR_W-1])
      nxt_rea = -power_in.rea;
  end

  // one registered sample per input sample, for the energy and pulse paths
  always_ff @(posedge clk_sys) begin
    if (!rst_n)
      accum_ff <= '0;
    else begin
      accum_ff.vld <= power_in.vld;
      if (power_in.vld) begin
        accum_ff.act <= nxt_act;
        accum_ff.rea <= nxt_rea;
      end
    end
  end

  assign accum_out = accum_ff;

  // ****************************************************************
  // sign and fault event detection
  // ****************************************************************
  // source picks filtered samples or the instants of each frequency pulse
  assign act_src_vld = gain_act_ff[SIGN_DETECTION_SOURCE] ? act_pulse : power_in.vld;
  assign rea_src_vld = gain_act_ff[SIGN_DETECTION_SOURCE] ? rea_pulse : power_in.vld;
  assign act_now_neg = power_in.act[PWR_W-1];
  assign rea_now_neg = power_in.rea[PWR_W-1];

  // first sample after reset only primes the history, so no false event
  assign act_evt = act_src_vld && act_seen_ff && (act_neg_ff != act_now_neg) &&
                   (act_now_neg != acc_mode_act_ff[ACTIVE_SIGN_EVENT_SELECT]);
  assign rea_evt = rea_src_vld && rea_seen_ff && (rea_neg_ff != rea_now_neg) &&
                   (rea_now_neg != acc_mode_act_ff[REACTIVE_SIGN_EVENT_SELECT]);
  assign fault_evt = (fault_ff != fault_mode) &&
                     (fault_mode != acc_mode_act_ff[FAULT_EVENT_SELECT]);

  // sign history
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      act_neg_ff  <= 1'b0;
      rea_neg_ff  <= 1'b0;
      act_seen_ff <= 1'b0;
      rea_seen_ff <= 1'b0;
      fault_ff    <= 1'b0;
    end else begin
      if (act_src_vld) begin
        act_neg_ff  <= act_now_neg;
        act_seen_ff <= 1'b1;
      end
      if (rea_src_vld) begin
        rea_neg_ff  <= rea_now_neg;
        rea_seen_ff <= 1'b1;
      end
      fault_ff <= fault_mode;
    end
  end

  // ****************************************************************
  // interrupt status, mask and output
  // ****************************************************************
  // write one clears, but an event in the same cycle keeps its flag
  always_comb begin
    nxt_irq_stat = irq_stat_ff;
    if (wr_stat)
      nxt_irq_stat = irq_stat_ff & ~bus_req.wdata[IRQ_FAULT:IRQ_LO];
    nxt_irq_stat = nxt_irq_stat | {fault_evt, rea_evt, act_evt};
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n)
      irq_stat_ff <= RST_IRQ;
    else
      irq_stat_ff <= nxt_irq_stat;
  end

  assign irq = |(irq_stat_ff & irq_mask_ff);

  // ****************************************************************
  // read port
  // ****************************************************************
  // data stand one cycle after the read strobe and read zero otherwise
  always_ff @(posedge clk_sys) begin
    if (!rst_n)
      rdata_ff <= 8'h00;
    else if (!bus_req.rd)
      rdata_ff <= 8'h00;
    else begin
      case (bus_req.addr)
        ADDR_ACC_MODE: rdata_ff <= {chan_b_ff, acc_mode_ff[6:0]};
        ADDR_GAIN:     rdata_ff <= gain_ff;
        ADDR_ZX_CTRL:  rdata_ff <= zx_ctrl_ff;
        ADDR_CAL_CTRL: rdata_ff <= cal_ctrl_ff;
        ADDR_IRQ_MASK: rdata_ff <= {2'h0, irq_mask_ff, 3'h0};
        ADDR_IRQ_STAT: rdata_ff <= {irq, 1'b0, irq_stat_ff, 3'h0};
        default:       rdata_ff <= 8'h00;
      endcase
    end
  end

  assign bus_rdata = rdata_ff;

endmodule : eagc_core

// [tb/eagc_core_sva.sv]
// Purpose: port-level assertions for eagc_core
// Assumes: one clock, synchronous active-low reset
// Notes:   watches ports only; bound after the module
`timescale 1ns/1ps
module eagc_core_sva
  import eagc_pkg::*;
(
  input wire logic                    clk_sys,
  input wire logic                    rst_n,
  input wire eagc_pkg::eagc_bus_req_t bus_req,
  input wire logic [7:0]              bus_rdata,
  input wire logic                    meas_update,
  input wire eagc_pkg::eagc_power_t   power_in,
  input wire logic                    act_pulse,
  input wire logic                    rea_pulse,
  input wire logic                    fault_mode,
  input wire eagc_pkg::eagc_power_t   accum_out,
  input wire logic [2:0]              voltage_gain_shift,
  input wire logic [2:0]              current_gain_shift,
  input wire logic                    current_input_b_sel,
  input wire logic                    voltage_input_short,
  input wire logic                    current_input_short,
  input wire logic                    zx_line_a_oe,
  input wire logic                    zx_line_b_oe,
  input wire logic                    irq
);
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // read strobe at one address
  sequence s_rd(logic [7:0] a);
    bus_req.rd && bus_req.addr == a;
  endsequence
  // clear-all write while no event source moves, so nothing can re-set a flag
  sequence s_quiet_clr;
    bus_req.wr && bus_req.addr == ADDR_IRQ_STAT && bus_req.wdata[5:3] == 3'h7 && !power_in.vld
      && !act_pulse && !rea_pulse && $stable(fault_mode);
  endsequence
  chk_gain_range: assert property (voltage_gain_shift <= GAIN_CODE_MAX && current_gain_shift <= GAIN_CODE_MAX)
    else $error("gain shift above largest code");
  chk_cfg_hold: assert property (!$past(meas_update) |->
    $stable({voltage_gain_shift, current_gain_shift, voltage_input_short, current_input_short}))
    else $error("config output moved without update");
  chk_zx_oe_hold: assert property (!$past(meas_update) |-> $stable({zx_line_a_oe, zx_line_b_oe}))
    else $error("zero-cross enable moved without update");
  chk_act_mag: assert property (accum_out.vld |-> accum_out.act == $past(power_in.act)
    || accum_out.act == -$past(power_in.act) || accum_out.act == '0)
    else $error("active result not derived from sample");
  chk_rea_mag: assert property (accum_out.vld |-> accum_out.rea == $past(power_in.rea)
    || accum_out.rea == -$past(power_in.rea))
    else $error("reactive result not derived from sample");
  chk_tamper_bit_read: assert property (s_rd(ADDR_ACC_MODE) |=> bus_rdata[7] == $past(current_input_b_sel))
    else $error("mode bit 7 differs from input used");
  chk_irq_summary: assert property (s_rd(ADDR_IRQ_STAT) |=> bus_rdata[7] == $past(irq))
    else $error("status summary differs from irq");
  chk_irq_clear: assert property (s_quiet_clr |=> !irq)
    else $error("irq stays after clearing all flags");
endmodule : eagc_core_sva

bind eagc_core eagc_core_sva u_sva (.clk_sys, .rst_n, .bus_req, .bus_rdata, .meas_update, .power_in, .act_pulse,
  .rea_pulse, .fault_mode, .accum_out, .voltage_gain_shift, .current_gain_shift, .current_input_b_sel,
  .voltage_input_short, .current_input_short, .zx_line_a_oe, .zx_line_b_oe, .irq);

// [tb/energy_accum_gain_config_test.sv]
// Purpose: self-checking bench for eagc_core against a behavioural model
// Assumes: 25 MHz clk_sys, inputs driven by non-blocking assignment at rising edges
// Notes:   pulse-instant sign mode runs last; the model does not follow its signs
`timescale 1ns/1ps
module energy_accum_gain_config_test;
  import eagc_pkg::*;
  logic          clk_sys = 1'b0;
  logic          rst_n = 1'b0;
  eagc_bus_req_t bus_req = '0;
  eagc_power_t   power_in = '0;
  eagc_power_t   accum_out;
  logic          meas_update = 1'b0, act_pulse = 1'b0, rea_pulse = 1'b0;
  logic          fault_mode = 1'b0, tamper_use_b = 1'b0, zero_cross = 1'b0;
  logic [7:0]    bus_rdata, acc, gain, mask, st, cal, ra[7];
  logic [2:0]    voltage_gain_shift, current_gain_shift;
  logic          current_input_b_sel, voltage_input_short, current_input_short, irq, eb, ei;
  logic          zx_line_a_out, zx_line_a_oe, zx_line_b_out, zx_line_b_oe;
  logic [31:0]   rv;
  logic [23:0]   a, r, ea, er;
  int            fails = 0, n_compared = 0, seed = 79, i, pa, pr;
  // free-running clock
  always #20 clk_sys = ~clk_sys;
  eagc_core uut (.clk_sys, .rst_n, .bus_req, .bus_rdata, .meas_update, .power_in, .act_pulse, .rea_pulse,
    .fault_mode, .tamper_use_b, .zero_cross, .accum_out, .voltage_gain_shift, .current_gain_shift,
    .current_input_b_sel, .voltage_input_short, .current_input_short, .zx_line_a_out, .zx_line_a_oe,
    .zx_line_b_out, .zx_line_b_oe, .irq);
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic cmp_reg(input logic [7:0] ad, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("BAD reg %h exp %h seen %h", ad, e, g);
    end
  endtask : cmp_reg
  task automatic cmp_out(input string nm, input logic [23:0] e, input logic [23:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h seen %h", nm, e, g);
    end
  endtask : cmp_out
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk_sys);
    bus_req <= '{ad, d, 1'b1, 1'b0};
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [7:0] ad, input logic [7:0] e);
    @(posedge clk_sys);
    bus_req <= '{ad, 8'h00, 1'b0, 1'b1};
    @(posedge clk_sys);
    bus_req.rd <= 1'b0;
    @(negedge clk_sys);
    cmp_reg(ad, e, bus_rdata);
  endtask : rd_chk
  // applied copies load on the edge that samples the pulse
  task automatic upd();
    @(posedge clk_sys);
    meas_update <= 1'b1;
    @(posedge clk_sys);
    meas_update <= 1'b0;
    @(negedge clk_sys);
  endtask : upd
  task automatic rst();
    @(posedge clk_sys);
    rst_n <= 1'b0;
    fault_mode <= 1'b0;
    tamper_use_b <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    {acc, gain, mask, st} = '0;
    eb = 1'b0;
    pa = -1;
    pr = -1;
  endtask : rst
  task automatic chk_stat();
    @(negedge clk_sys);
    ei = (st & mask & 8'h38) != 8'h00;
    cmp_out("irq", ei, irq);
    rd_chk(ADDR_IRQ_STAT, st | {ei, 7'h00});
  endtask : chk_stat
  // one sample; pulses only in filtered-sign mode, where they must not count
  task automatic sample();
    rv = $random(seed);
    a = rv[23:0];
    rv = $random(seed);
    r = rv[23:0];
    @(posedge clk_sys);
    power_in <= '{1'b1, a, r};
    act_pulse <= rv[31] & !gain[3];
    rea_pulse <= rv[30] & !gain[3];
    ea = acc[0] ? (a[23] ? -a : a) : (acc[1] && a[23]) ? 24'h0 : a;
    er = acc[3] ? (r[23] ? -r : r) : (acc[2] && a[23]) ? -r : r;
    if (!gain[3]) begin
      if (pa >= 0 && pa != a[23] && a[23] != acc[4]) st[3] = 1'b1;
      if (pr >= 0 && pr != r[23] && r[23] != acc[5]) st[4] = 1'b1;
      pa = a[23];
      pr = r[23];
    end
    @(posedge clk_sys);
    power_in.vld <= 1'b0;
    act_pulse <= 1'b0;
    rea_pulse <= 1'b0;
    @(negedge clk_sys);
    cmp_out("act", ea, accum_out.act);
    cmp_out("rea", er, accum_out.rea);
  endtask : sample
  // hang guard, far beyond the roughly 1400 cycles the run needs
  initial begin
    #1000000;
    fails++;
    end_of_test();
  end
  // main sequence
  initial begin
    ra = '{ADDR_ACC_MODE, ADDR_GAIN, ADDR_ZX_CTRL, ADDR_CAL_CTRL, ADDR_IRQ_MASK, ADDR_IRQ_STAT, 8'h55};
    rst();
    for (i = 0; i < 7; i++) rd_chk(ra[i], 8'h00);
    for (i = 0; i < 8; i++) begin
      gain = {i[2:0], 2'b10, ~i[2:0]} & GAIN_WR_MASK;
      wr(ADDR_GAIN, gain | 8'h10);
      rd_chk(ADDR_GAIN, gain);
      upd();
      cmp_out("vgain", (i > 4) ? 4 : i, voltage_gain_shift);
      cmp_out("cgain", (i < 3) ? 4 : 7 - i, current_gain_shift);
    end
    for (i = 0; i < 4; i++) begin
      rv = $random(seed);
      wr(ADDR_ZX_CTRL, {rv[5:0], i[1:0]});
      rd_chk(ADDR_ZX_CTRL, {6'h00, i[1:0]});
      upd();
      @(posedge clk_sys);
      zero_cross <= rv[7];
      @(negedge clk_sys);
      cmp_out("zx_oe", i[1:0], {zx_line_a_oe, zx_line_b_oe});
      cmp_out("zx_out", {2{rv[7]}}, {zx_line_a_out, zx_line_b_out});
    end
    for (i = 0; i < 8; i++) begin
      rv = $random(seed);
      cal = {2'b00, i[1:0], rv[1:0], 2'b00};
      wr(ADDR_CAL_CTRL, cal);
      @(posedge clk_sys);
      tamper_use_b <= i[2];
      upd();
      // input choice is registered from the applied copy, so one more edge
      @(negedge clk_sys);
      eb = (i[1:0] == SEL_FORCE_A) ? 1'b0 : (i[1:0] == SEL_FORCE_B) ? 1'b1 : i[2];
      cmp_out("b_sel", eb, current_input_b_sel);
      cmp_out("shorts", rv[1:0], {voltage_input_short, current_input_short});
      rd_chk(ADDR_CAL_CTRL, cal);
      rd_chk(ADDR_ACC_MODE, {eb, 7'h00});
    end
    // every mode combination, random event selects, masks and clears
    for (i = 0; i < 48; i++) begin
      rv = $random(seed);
      acc = {1'b0, rv[6:4], i[3:0]};
      mask = rv[15:8] & 8'h38;
      wr(ADDR_ACC_MODE, {rv[7], acc[6:0]});
      wr(ADDR_IRQ_MASK, mask);
      upd();
      rd_chk(ADDR_ACC_MODE, {eb, acc[6:0]});
      rd_chk(ADDR_IRQ_MASK, mask);
      repeat (3) sample();
      @(posedge clk_sys);
      fault_mode <= ~fault_mode;
      if (fault_mode == acc[6]) st[5] = 1'b1;
      @(posedge clk_sys);
      chk_stat();
      wr(ADDR_IRQ_STAT, rv[23:16]);
      st = st & ~(rv[23:16] & 8'h38);
      chk_stat();
    end
    // pulse-instant sign source: samples alone raise no sign flag
    gain = 8'h08;
    wr(ADDR_GAIN, gain);
    upd();
    wr(ADDR_IRQ_STAT, 8'h38);
    st = 8'h00;
    repeat (6) sample();
    chk_stat();
    rst();
    rd_chk(ADDR_GAIN, 8'h00);
    cmp_out("b_sel", 1'b0, current_input_b_sel);
    end_of_test();
  end
endmodule : energy_accum_gain_config_test
